// ---- rtl/sleep_ctrl_pkg.sv ----
// constants, enums and structs shared by the sleep/wakeup control block
package sleep_ctrl_pkg;

  // apb register map, byte addresses
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] MASK_OFS   = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] CMD_OFS    = 12'h00C;

  // system_control_reg field positions
  localparam int AFTER_HANDLER_BIT = 1;
  localparam int DEEP_SELECT_BIT   = 2;
  localparam int PEND_EVENT_BIT    = 4;

  // mask register field positions
  localparam int PRIO_MASK_BIT  = 0;
  localparam int FAULT_MASK_BIT = 1;

  // command register: self-clearing strobes
  localparam int CMD_WAIT_INT_BIT   = 0;
  localparam int CMD_WAIT_EVT_BIT   = 1;
  localparam int CMD_SIGNAL_EVT_BIT = 2;

  // status register field positions
  localparam int ST_LIGHT_BIT  = 0;
  localparam int ST_DEEP_BIT   = 1;
  localparam int ST_EVENT_BIT  = 2;
  localparam int ST_BYEVT_BIT  = 3;
  localparam int ST_HELD_BIT   = 4;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0]  MASK_RESET = 2'h0;

  // deep sleep: clock stop before pll/flash off, restore in reverse
  localparam int PWR_SETTLE_NS     = 100;
  localparam int CLK_PERIOD_NS     = 10;
  localparam int PWR_SETTLE_CYCLES =
    (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SETTLE_LOAD = 4'(PWR_SETTLE_CYCLES);

  typedef enum logic [4:0] {
    ST_RUN       = 5'h01,
    ST_LIGHT     = 5'h02,
    ST_DEEP_GATE = 5'h04,
    ST_DEEP      = 5'h08,
    ST_DEEP_WAKE = 5'h10
  } pwr_state_e;

  // wake sources as seen by the sequencer
  typedef struct packed {
    logic exc_entry;
    logic irq_wake_held;
    logic event_wake;
    logic spurious;
  } wake_s;

  // power controls to the clock and power domains
  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_en;
    logic pll_en;
    logic flash_en;
  } pwr_ctl_s;

endpackage

// ---- rtl/event_latch.sv ----
// one-bit event register with set-wins-over-clear behaviour
`timescale 1ns/100ps
module event_latch (
  input  wire logic CLOCK,
  input  wire logic RST,
  input  wire logic set_in,
  input  wire logic consume,
  output logic      event_q
);
  logic event_r;
  logic event_nxt;

  always_comb begin
    event_nxt = event_r;
    if (consume) begin
      event_nxt = 1'b0;
    end
    // a set arriving with the consume is kept
    if (set_in) begin
      event_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      event_r <= 1'b0;
    end else begin
      event_r <= event_nxt;
    end
  end

  assign event_q = event_r;
endmodule

// ---- rtl/pend_edge.sv ----
// per-line rising edge detector for pending interrupts
`timescale 1ns/100ps
module pend_edge #(
  parameter int N = 8
) (
  input  wire logic         CLOCK,
  input  wire logic         RST,
  input  wire logic [N-1:0] pend_in,
  output logic              new_pend
);
  logic [N-1:0] prev_r;
  logic [N-1:0] rise;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_line
      assign rise[i] = pend_in[i] & ~prev_r[i];
    end
  endgenerate

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      prev_r <= '0;
    end else begin
      prev_r <= pend_in;
    end
  end

  assign new_pend = |rise;
endmodule

// ---- rtl/sleep_ctrl.sv ----
// processor sleep and wakeup controller with apb register access
// Operation
// [RULE1] light sleep gates cpu clock only
// [RULE2] deep sleep stops system clock, pll, flash
// [RULE3] deep select bit picks sleep depth
// [RULE4] wait interrupt op sleeps unconditionally
// [RULE5] wait event sleeps when event clear
// [RULE6] wait event with event set: consume, continue
// [RULE7] sleep after handler on handler return
// [RULE8] interrupt-wait sleep ends on exception entry
// [RULE9] priority mask wakes but holds handler
// [RULE10] event-wait sleep ends on exception entry
// [RULE11] external event input wakes event-wait sleep
// [RULE12] other processor signal event wakes too
// [RULE13] pending as event: new pending wakes
// [RULE14] event input while awake sets event
// [RULE15] spurious wake, e.g. debug, allowed
// [RULE16] event register cleared on reset
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
module sleep_ctrl
  import sleep_ctrl_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [11:0] PADDR,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        WAIT_INT_OP,
  input  wire logic        WAIT_EVT_OP,
  input  wire logic        HANDLER_DONE,
  input  wire logic        EXC_REQ,
  input  wire logic        EXC_IS_IRQ,
  input  wire logic        FAULT_CLASS,
  input  wire logic [7:0]  IRQ_PENDING,
  input  wire logic        EXT_EVENT,
  input  wire logic        REMOTE_SIGNAL_EVT,
  input  wire logic        DEBUG_WAKE,
  output logic             CPU_HALT,
  output logic             HANDLER_HOLD,
  output logic             SIGNAL_EVT_OUT,
  output logic             CPU_CLK_EN,
  output logic             SYS_CLK_EN,
  output logic             PLL_EN,
  output logic             FLASH_EN
);
  import sleep_ctrl_pkg::*;

  // ---------------- register state ----------------
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [1:0]  mask_r, mask_nxt;
  logic [2:0]  cmd_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        sig_out_r, sig_out_nxt;

  // ---------------- sequencer state ----------------
  pwr_state_e  state_r, state_nxt;
  logic        by_event_r, by_event_nxt;
  logic        hold_r, hold_nxt;
  logic [3:0]  settle_r, settle_nxt;
  pwr_ctl_s    pwr_r, pwr_nxt;
  logic        halt_r, halt_nxt;

  logic        apb_setup;
  logic        wr_hit;
  logic        deep_sel;
  logic        after_handler;
  logic        pend_evt_en;
  logic        prio_mask;
  logic        fault_mask;
  logic        wait_int_any;
  logic        wait_evt_any;
  logic        evt_q;
  logic        evt_consume;
  logic        evt_set;
  logic        new_pend;
  logic        exc_ok;
  logic        masked_irq;
  logic        sleeping;
  wake_s       wake;
  logic        wake_now;
  logic        enter;

  assign deep_sel      = ctrl_r[DEEP_SELECT_BIT];
  assign after_handler = ctrl_r[AFTER_HANDLER_BIT];
  assign pend_evt_en   = ctrl_r[PEND_EVENT_BIT];
  assign prio_mask     = mask_r[PRIO_MASK_BIT];
  assign fault_mask    = mask_r[FAULT_MASK_BIT];

  // pready rises in the access cycle itself, so accesses have no wait state
  assign apb_setup = PSEL & ~PENABLE;
  assign wr_hit    = PSEL & PENABLE & PWRITE & pready_r;

  assign wait_int_any = WAIT_INT_OP | cmd_nxt[CMD_WAIT_INT_BIT];
  assign wait_evt_any = WAIT_EVT_OP | cmd_nxt[CMD_WAIT_EVT_BIT];
  assign sleeping     = (state_r != ST_RUN);

  pend_edge #(
    .N        (8)
  ) u_pend (
    .CLOCK    (CLOCK),
    .RST      (RST),
    .pend_in  (IRQ_PENDING),
    .new_pend (new_pend)
  );

  // exceptions allowed to enter their handler under the masks
  always_comb begin
    exc_ok     = 1'b0;
    masked_irq = 1'b0;
    if (EXC_REQ) begin
      if (fault_mask) begin
        exc_ok = 1'b0;
      end else if (prio_mask && EXC_IS_IRQ && !FAULT_CLASS) begin
        masked_irq = 1'b1; // RULE9
      end else begin
        exc_ok = 1'b1;
      end
    end
  end

  // event register sources while running; a wait-event with the event
  // already set consumes it instead of sleeping
  always_comb begin
    evt_set = 1'b0;
    if (!sleeping && EXT_EVENT) begin
      evt_set = 1'b1; // RULE14
    end
    if (!sleeping && REMOTE_SIGNAL_EVT) begin
      evt_set = 1'b1;
    end
    if (!sleeping && pend_evt_en && new_pend) begin
      evt_set = 1'b1;
    end
    evt_consume = (state_r == ST_RUN) && !wait_int_any &&
                  wait_evt_any && evt_q; // RULE6
  end

  event_latch u_evt (
    .CLOCK   (CLOCK),
    .RST     (RST), // RULE16
    .set_in  (evt_set),
    .consume (evt_consume),
    .event_q (evt_q)
  );

  // wake qualification depends on how sleep was entered
  always_comb begin
    wake.exc_entry     = exc_ok; // RULE8 RULE10
    wake.irq_wake_held = masked_irq; // RULE9
    wake.event_wake    = by_event_r &&
                         (EXT_EVENT || // RULE11
                          REMOTE_SIGNAL_EVT || // RULE12
                          (pend_evt_en && new_pend)); // RULE13
    wake.spurious      = DEBUG_WAKE; // RULE15
    wake_now = |wake;
  end

  always_comb begin
    enter = 1'b0;
    if (wait_int_any) begin
      enter = 1'b1; // RULE4
    end else if (wait_evt_any && !evt_q) begin
      enter = 1'b1; // RULE5
    end else if (HANDLER_DONE && after_handler) begin
      enter = 1'b1; // RULE7
    end
  end

  // ---------------- sleep sequencer ----------------
  always_comb begin
    state_nxt    = state_r;
    by_event_nxt = by_event_r;
    hold_nxt     = hold_r;
    settle_nxt   = settle_r;
    pwr_nxt      = pwr_r;
    if (!prio_mask || fault_mask) begin
      hold_nxt = 1'b0; // RULE9
    end
    case (state_r)
      ST_RUN: begin
        if (enter) begin
          by_event_nxt = !wait_int_any && wait_evt_any;
          pwr_nxt.cpu_clk_en = 1'b0;
          if (deep_sel) begin
            state_nxt = ST_DEEP_GATE; // RULE3
          end else begin
            state_nxt = ST_LIGHT; // RULE3
          end
        end
      end
      ST_LIGHT: begin
        pwr_nxt.sys_clk_en = 1'b1; // RULE1
        if (wake_now) begin
          hold_nxt = masked_irq;
          pwr_nxt.cpu_clk_en = 1'b1;
          by_event_nxt = 1'b0;
          state_nxt = ST_RUN;
        end
      end
      ST_DEEP_GATE: begin
        // a wake pulse here would be lost once the system clock stops
        if (wake_now) begin
          hold_nxt = masked_irq;
          pwr_nxt.cpu_clk_en = 1'b1;
          by_event_nxt = 1'b0;
          state_nxt = ST_RUN;
        end else begin
          // stop the system clock first, then power down after settling
          pwr_nxt.sys_clk_en = 1'b0; // RULE2
          settle_nxt = SETTLE_LOAD;
          state_nxt = ST_DEEP;
        end
      end
      ST_DEEP: begin
        if (settle_r != 4'h0) begin
          settle_nxt = settle_r - 4'h1;
          if (settle_r == 4'h1) begin
            pwr_nxt.pll_en = 1'b0; // RULE2
            pwr_nxt.flash_en = 1'b0; // RULE2
          end
        end
        if (wake_now) begin
          hold_nxt = masked_irq;
          pwr_nxt.pll_en = 1'b1;
          pwr_nxt.flash_en = 1'b1;
          settle_nxt = SETTLE_LOAD;
          state_nxt = ST_DEEP_WAKE;
        end
      end
      ST_DEEP_WAKE: begin
        // let pll and flash settle before clocks come back
        if (settle_r != 4'h0) begin
          settle_nxt = settle_r - 4'h1;
        end else begin
          pwr_nxt.sys_clk_en = 1'b1;
          pwr_nxt.cpu_clk_en = 1'b1;
          by_event_nxt = 1'b0;
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
        pwr_nxt = '1;
      end
    endcase
    halt_nxt = !pwr_nxt.cpu_clk_en;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r    <= ST_RUN;
      by_event_r <= 1'b0;
      hold_r     <= 1'b0;
      settle_r   <= 4'h0;
      pwr_r      <= '1;
      halt_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      by_event_r <= by_event_nxt;
      hold_r     <= hold_nxt;
      settle_r   <= settle_nxt;
      pwr_r      <= pwr_nxt;
      halt_r     <= halt_nxt;
    end
  end

  // ---------------- apb slave ----------------
  always_comb begin
    ctrl_nxt    = ctrl_r;
    mask_nxt    = mask_r;
    cmd_nxt     = 3'h0;
    sig_out_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    pready_nxt  = apb_setup;
    pslverr_nxt = 1'b0;
    if (apb_setup) begin
      prdata_nxt = 32'h0000_0000;
      case (PADDR)
        CTRL_OFS:   prdata_nxt = ctrl_r;
        MASK_OFS:   prdata_nxt = {30'h0, mask_r};
        STATUS_OFS: begin
          prdata_nxt[ST_LIGHT_BIT] = (state_r == ST_LIGHT);
          prdata_nxt[ST_DEEP_BIT]  = (state_r != ST_RUN) &&
                                     (state_r != ST_LIGHT);
          prdata_nxt[ST_EVENT_BIT] = evt_q;
          prdata_nxt[ST_BYEVT_BIT] = by_event_r;
          prdata_nxt[ST_HELD_BIT]  = hold_r;
        end
        CMD_OFS:    prdata_nxt = 32'h0000_0000;
        default:    pslverr_nxt = 1'b1;
      endcase
    end
    if (wr_hit && !pslverr_r) begin
      case (PADDR)
        CTRL_OFS: begin
          if (PSTRB[0]) begin
            ctrl_nxt[7:0] = PWDATA[7:0] &
              8'((1 << AFTER_HANDLER_BIT) | (1 << DEEP_SELECT_BIT) |
                 (1 << PEND_EVENT_BIT));
          end
        end
        MASK_OFS: begin
          if (PSTRB[0]) begin
            mask_nxt = PWDATA[1:0];
          end
        end
        CMD_OFS: begin
          if (PSTRB[0]) begin
            cmd_nxt = PWDATA[2:0];
            sig_out_nxt = PWDATA[CMD_SIGNAL_EVT_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_r    <= CTRL_RESET;
      mask_r    <= MASK_RESET;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      sig_out_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      mask_r    <= mask_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      sig_out_r <= sig_out_nxt;
    end
  end

  assign PRDATA         = prdata_r;
  assign PREADY         = pready_r;
  assign PSLVERR        = pslverr_r;
  assign SIGNAL_EVT_OUT = sig_out_r;
  assign CPU_HALT       = halt_r;
  assign HANDLER_HOLD   = hold_r;
  assign CPU_CLK_EN     = pwr_r.cpu_clk_en;
  assign SYS_CLK_EN     = pwr_r.sys_clk_en;
  assign PLL_EN         = pwr_r.pll_en;
  assign FLASH_EN       = pwr_r.flash_en;
endmodule

// ---- verification/sleep_ctrl_sva.sv ----
// port-level assertions for the sleep and wakeup controller
`timescale 1ns/100ps
module sleep_ctrl_chk (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic [11:0] PADDR,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        WAIT_INT_OP,
  input wire logic        WAIT_EVT_OP,
  input wire logic        HANDLER_DONE,
  input wire logic        EXC_REQ,
  input wire logic        EXC_IS_IRQ,
  input wire logic        FAULT_CLASS,
  input wire logic        SIGNAL_EVT_OUT,
  input wire logic        EXT_EVENT,
  input wire logic        REMOTE_SIGNAL_EVT,
  input wire logic        CPU_HALT,
  input wire logic        HANDLER_HOLD,
  input wire logic        CPU_CLK_EN,
  input wire logic        SYS_CLK_EN,
  input wire logic        PLL_EN,
  input wire logic        FLASH_EN
);
  import sleep_ctrl_pkg::*;
  logic [4:0] ctl_r, ctl_nxt;
  logic [1:0] msk_r, msk_nxt;
  logic       evt_wait_r, evt_wait_nxt;
  wire        wr = PSEL && PENABLE && PWRITE && PREADY;
  wire        run = CPU_CLK_EN && PLL_EN && !CPU_HALT;
  // shadow of the control fields, so depth and wake kind are known here
  always_comb begin
    ctl_nxt = ctl_r;
    msk_nxt = msk_r;
    evt_wait_nxt = evt_wait_r;
    if (wr && PADDR == CTRL_OFS) ctl_nxt = PWDATA[4:0];
    if (wr && PADDR == MASK_OFS) msk_nxt = PWDATA[1:0];
    if (run && (WAIT_INT_OP || HANDLER_DONE)) evt_wait_nxt = 1'h0;
    if (run && WAIT_EVT_OP) evt_wait_nxt = 1'h1;
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctl_r <= 5'h00;
      msk_r <= 2'h0;
      evt_wait_r <= 1'h0;
    end else begin
      ctl_r <= ctl_nxt;
      msk_r <= msk_nxt;
      evt_wait_r <= evt_wait_nxt;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  chk_light_sys: assert property (
    $fell(CPU_CLK_EN) |-> SYS_CLK_EN) else $error("sys clock at entry");
  chk_deep_order: assert property (
    !PLL_EN || !FLASH_EN |-> !SYS_CLK_EN && !CPU_CLK_EN && PLL_EN == FLASH_EN)
    else $error("deep power order");
  chk_depth_pick: assert property (
    run && WAIT_INT_OP && !EXC_REQ |->
    ##2 SYS_CLK_EN == !ctl_r[DEEP_SELECT_BIT]) else $error("sleep depth");
  chk_wfi_sleep: assert property (
    run && WAIT_INT_OP && !EXC_REQ |=> CPU_HALT && !CPU_CLK_EN)
    else $error("no sleep on wait");
  chk_exit_sleep: assert property (
    run && HANDLER_DONE && !EXC_REQ && ctl_r[AFTER_HANDLER_BIT]
    |=> !CPU_CLK_EN) else $error("no sleep on return");
  chk_exc_wake: assert property (
    CPU_HALT && EXC_REQ && !msk_r[FAULT_MASK_BIT] |-> ##[1:30] !CPU_HALT)
    else $error("no exception wake");
  chk_prio_hold: assert property (
    CPU_HALT && EXC_REQ && EXC_IS_IRQ && !FAULT_CLASS && msk_r == 2'h1
    |-> ##[1:30] HANDLER_HOLD) else $error("handler not held");
  chk_evt_wake: assert property (
    CPU_HALT && evt_wait_r && (EXT_EVENT || REMOTE_SIGNAL_EVT)
    |-> ##[1:30] !CPU_HALT) else $error("no event wake");
  chk_evt_preset: assert property (
    (run && EXT_EVENT) ##1 (run && WAIT_EVT_OP) |=> CPU_CLK_EN)
    else $error("slept on set event");
  chk_sig_pulse: assert property (
    SIGNAL_EVT_OUT |=> !SIGNAL_EVT_OUT) else $error("signal pulse width");
  cover property (run && WAIT_EVT_OP);
  cover property (!PLL_EN);
  cover property (HANDLER_HOLD);
endmodule

// ---- verification/event_src.sv ----
// far side: peripheral event line, remote core signal, irq lines
`timescale 1ns/100ps
module event_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [1:0] kind,
  input  wire logic [3:0] dly,
  output logic            ext_evt,
  output logic            rem_evt,
  output logic [7:0]      pend
);
  logic [3:0] cnt_r;
  logic [1:0] k_r;
  wire        fire = cnt_r == 4'h1;
  // delay lets the source answer promptly or late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      k_r   <= 2'h0;
      pend  <= 8'h00;
    end else begin
      if (go) begin
        cnt_r <= dly + 4'h1;
        k_r   <= kind;
      end else if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      if (fire && k_r == 2'h2)
        pend <= {pend[6:0], 1'h1};
    end
  end
  assign ext_evt = fire && k_r == 2'h0;
  assign rem_evt = fire && k_r == 2'h1;
endmodule

// ---- verification/tb_top.sv ----
// self-checking testbench for the sleep and wakeup controller
`timescale 1ns/100ps
module tb_top;
  import sleep_ctrl_pkg::*;
  logic        CLOCK = 1'h0;
  logic        RST = 1'h1;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
  logic        WAIT_INT_OP, WAIT_EVT_OP, HANDLER_DONE, DEBUG_WAKE;
  logic        EXC_REQ, EXC_IS_IRQ, EXT_EVENT, REMOTE_SIGNAL_EVT;
  logic        CPU_HALT, HANDLER_HOLD, SIGNAL_EVT_OUT, go;
  logic        CPU_CLK_EN, SYS_CLK_EN, PLL_EN, FLASH_EN;
  logic [7:0]  IRQ_PENDING;
  logic [1:0]  kind;
  logic [3:0]  dly;
  logic [3:0]  PSTRB = 4'hF;
  logic        FAULT_CLASS = 1'h0;
  int          bad_count, checks_done, ticks;
  always #5 CLOCK = ~CLOCK;
  sleep_ctrl i_dut (.*);
  event_src i_src (.clk(CLOCK), .rst(RST), .go(go), .kind(kind), .dly(dly),
    .ext_evt(EXT_EVENT), .rem_evt(REMOTE_SIGNAL_EVT), .pend(IRQ_PENDING));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    ticks++;
    if (ticks == 3000) begin
      bad_count++;
      end_sim;
    end
  end
  task automatic chk(input string n, input logic [31:0] x, g);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  // halt, hold, cpu clk, sys clk, pll, flash
  task automatic st(input logic [5:0] x);
    chk("pins", 32'(x), 32'({CPU_HALT, HANDLER_HOLD, CPU_CLK_EN,
      SYS_CLK_EN, PLL_EN, FLASH_EN}));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'h1;
    do @(posedge CLOCK); while (PREADY !== 1'h1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task automatic rd(input string n, input logic [11:0] a,
                    input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(n, x, q);
  endtask
  task automatic op(input logic [3:0] k);
    @(posedge CLOCK);
    {DEBUG_WAKE, HANDLER_DONE, WAIT_EVT_OP, WAIT_INT_OP} <= k;
    @(posedge CLOCK);
    {DEBUG_WAKE, HANDLER_DONE, WAIT_EVT_OP, WAIT_INT_OP} <= 4'h0;
  endtask
  task automatic ev(input logic [1:0] k, input logic [3:0] d);
    @(posedge CLOCK);
    kind <= k;
    dly <= d;
    go <= 1'h1;
    @(posedge CLOCK);
    go <= 1'h0;
  endtask
  task automatic exc(input logic [1:0] v);
    @(posedge CLOCK);
    {EXC_IS_IRQ, EXC_REQ} <= v;
  endtask
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, go, kind, dly} = '0;
    {DEBUG_WAKE, HANDLER_DONE, WAIT_EVT_OP, WAIT_INT_OP} = 4'h0;
    {EXC_IS_IRQ, EXC_REQ} = 2'h0;
    cyc(4);
    RST <= 1'h0;
    st(6'h0F);
    rd("ctrl", CTRL_OFS, 32'h0);
    rd("mask", MASK_OFS, 32'h0);
    rd("status", STATUS_OFS, 32'h0);
    apb(1'h1, 12'h010, 32'hF);
    chk("slverr", 32'h1, 32'(e));
    op(4'h1);
    cyc(2);
    st(6'h27);
    ev(2'h0, 4'h0);
    cyc(4);
    st(6'h27);
    exc(2'h1);
    cyc(4);
    st(6'h0F);
    exc(2'h0);
    apb(1'h1, CTRL_OFS, 32'h4);
    op(4'h1);
    cyc(15);
    st(6'h20);
    exc(2'h1);
    cyc(25);
    st(6'h0F);
    exc(2'h0);
    apb(1'h1, CTRL_OFS, 32'h10);
    ev(2'h0, 4'h0);
    op(4'h2);
    cyc(2);
    st(6'h0F);
    ev(2'h0, 4'h0);
    cyc(2);
    rd("event", STATUS_OFS, 32'h4);
    op(4'h2);
    rd("event", STATUS_OFS, 32'h0);
    // one wait-event sleep per wake source, answered after a delay of 0, 3 and 6 cycles
    for (int k = 0; k < 3; k++) begin
      op(4'h2);
      cyc(2);
      st(6'h27);
      ev(2'(k), 4'(3 * k));
      cyc(3 * k + 6);
      st(6'h0F);
    end
    apb(1'h1, CTRL_OFS, 32'h2);
    op(4'h4);
    cyc(2);
    st(6'h27);
    op(4'h8);
    cyc(3);
    st(6'h0F);
    apb(1'h1, MASK_OFS, 32'h1);
    apb(1'h1, CMD_OFS, 32'h1);
    cyc(2);
    st(6'h27);
    exc(2'h3);
    cyc(4);
    st(6'h1F);
    apb(1'h1, MASK_OFS, 32'h0);
    cyc(2);
    st(6'h0F);
    exc(2'h0);
    // a fault is not held back by the priority mask
    FAULT_CLASS <= 1'h1;
    apb(1'h1, MASK_OFS, 32'h1);
    op(4'h1);
    cyc(2);
    st(6'h27);
    exc(2'h3);
    cyc(4);
    st(6'h0F);
    exc(2'h0);
    FAULT_CLASS <= 1'h0;
    // fault mask blocks the exception wake, debug wake still ends it
    apb(1'h1, MASK_OFS, 32'h2);
    op(4'h1);
    exc(2'h1);
    cyc(4);
    st(6'h27);
    op(4'h8);
    cyc(3);
    st(6'h0F);
    exc(2'h0);
    // own signal-event strobe is a one-cycle pulse to the other core
    apb(1'h1, CMD_OFS, 32'h4);
    cyc(1);
    chk("sig_evt", 32'h1, 32'(SIGNAL_EVT_OUT));
    cyc(1);
    chk("sig_evt", 32'h0, 32'(SIGNAL_EVT_OUT));
    end_sim;
  end
endmodule
bind sleep_ctrl sleep_ctrl_chk i_chk (.*);
